// [src/host_ctrl_state.sv]
// Functional notes
// RULE1: Bit 9 of the control register reports remote wake-up support.
// RULE2: Firmware sets the wake-connected bit at power-on when used.
// RULE3: Wake-connected clears on hardware reset, survives software reset.
// RULE4: With routing bit 8 low, status interrupts go to the bus interrupt.
// RULE5: With routing bit high, status interrupts go to the management one.
// RULE6: The driver clears routing on hardware reset, keeps it on software.
// RULE7: The driver uses the routing bit as an ownership tag.
// RULE8: Bits 7:6 encode reset 00, resume 01, running 10, suspended 11.
// RULE9: Frames start one millisecond after entering the running state.
// RULE10: Status bit 2 tells the driver that frame sending has begun.
// RULE11: Hardware alters the state field only while it is suspended.
// RULE12: When suspended, port resume signaling moves the state to resume.
// RULE13: Software reset enters suspend; hardware reset enters bus reset.
// RULE14: Wake enable with resume detected signals wake to the host.
// RULE15: Software writes reserved control bits with their reset value.
//
// Chosen here: register access over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none

module host_ctrl_state
  import host_ctrl_pkg::*;
#(
  parameter int unsigned frame_cycles = frame_delay_cycles
) (
  // Clock and reset.
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite slave.
  input  wire logic        hsel,
  input  wire logic [11:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic        hready,
  input  wire logic [31:0] hwdata,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // Downstream port events, asynchronous.
  input  wire logic        port_resume_detect,
  // System side.
  output logic             bus_irq,
  output logic             mgmt_irq,
  output logic             host_wake,
  output logic             port_reset_drive,
  output logic             frame_enable
);

  initial begin
    if (frame_cycles < 1) begin
      $error("frame_cycles must be at least one");
    end
    // Overlapping offsets would let one write land in two registers.
    if ((ctrl_offset == int_status_offset) ||
        (ctrl_offset == int_enable_offset) ||
        (ctrl_offset == sw_reset_offset) ||
        (int_status_offset == int_enable_offset) ||
        (int_status_offset == sw_reset_offset) ||
        (int_enable_offset == sw_reset_offset)) begin
      $error("register offsets must be distinct");
    end
  end

  // Address phase capture.
  logic        wr_pend;
  logic        rd_pend;
  logic [11:0] addr_q;
  logic        next_wr_pend;
  logic        next_rd_pend;
  logic [11:0] next_addr_q;

  // Register state.
  logic [31:0] ctrl;
  logic [31:0] int_status;
  logic [31:0] int_enable;
  logic [31:0] next_ctrl;
  logic [31:0] next_int_status;
  logic [31:0] next_int_enable;
  logic [31:0] next_hrdata;
  logic        next_bus_irq;
  logic        next_mgmt_irq;
  logic        next_host_wake;
  logic        next_port_reset_drive;
  logic        next_frame_enable;
  logic [1:0]  prev_state;
  logic [1:0]  next_prev_state;

  // Resume input synchroniser.
  logic        resume_meta;
  logic        resume_sync;

  logic        frame_started;
  logic        frame_pulse;
  logic        arm;
  logic        running;

  function automatic logic [31:0] read_mux(
    input logic [11:0] a,
    input logic [31:0] c,
    input logic [31:0] s,
    input logic [31:0] e
  );
    case (a)
      ctrl_offset:       read_mux = c;
      int_status_offset: read_mux = s;
      int_enable_offset: read_mux = e;
      default:           read_mux = 32'h0000_0000;
    endcase
  endfunction

  // A transfer is taken when selected, ready and a new single transfer.
  function automatic logic take_transfer(
    input logic       sel,
    input logic       rdy,
    input logic [1:0] trans
  );
    take_transfer = sel && rdy && (trans == htrans_nonseq);
  endfunction

  // Pulls the two-bit functional state out of a control word.
  function automatic functional_state_t state_of(input logic [31:0] c);
    state_of = functional_state_t'(c[fs_hi:fs_lo]);
  endfunction

  // True when the pending data phase writes the register at this offset.
  function automatic logic write_to(
    input logic        pend,
    input logic [11:0] a,
    input logic [11:0] offset
  );
    write_to = pend && (a == offset);
  endfunction

  // Control bits that a software reset leaves untouched.
  function automatic logic [31:0] sw_reset_keep(input logic [31:0] c);
    sw_reset_keep = c & ((32'h0000_0001 << bit_wake_connected) |
                         (32'h0000_0001 << bit_irq_route));
  endfunction

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      resume_meta <= 1'b0;
      resume_sync <= 1'b0;
    end else begin
      resume_meta <= port_resume_detect;
      resume_sync <= resume_meta;
    end
  end

  assign running = (state_of(ctrl) == state_running);
  // The timer restarts only on entry into running, not while it stays.
  assign arm     = running && (prev_state != state_running); // [RULE9]

  frame_start_timer #(
    .delay_cycles (frame_cycles)
  ) u_timer (
    .hclk        (hclk),
    .hresetn     (hresetn),
    .arm         (arm),
    .running     (running),
    .started     (frame_started),
    .start_pulse (frame_pulse)
  );

  // Address phase capture for the following data phase.
  always_comb begin
    next_wr_pend = 1'b0;
    next_rd_pend = 1'b0;
    next_addr_q  = addr_q;
    if (take_transfer(hsel, hready, htrans)) begin
      next_wr_pend = hwrite;
      next_rd_pend = !hwrite;
      next_addr_q  = haddr;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      rd_pend <= 1'b0;
      addr_q  <= 12'h000;
    end else begin
      wr_pend <= next_wr_pend;
      rd_pend <= next_rd_pend;
      addr_q  <= next_addr_q;
    end
  end

  always_comb begin
    logic        wr_hit;
    logic        sw_reset;
    logic [31:0] wval;
    logic [31:0] events;
    logic [31:0] pending;
    wr_hit   = 1'b0;
    sw_reset = 1'b0;
    wval     = hwdata;
    events   = 32'h0000_0000;
    pending  = 32'h0000_0000;

    next_ctrl       = ctrl;
    next_int_status = int_status;
    next_int_enable = int_enable;
    wr_hit          = wr_pend;

    if (write_to(wr_hit, addr_q, ctrl_offset)) begin
      // Reserved bits keep their reset value whatever is written.
      next_ctrl = (wval & ctrl_rw_mask) |
                  (ctrl_reset_value & ~ctrl_rw_mask); // [RULE15]
    end
    if (write_to(wr_hit, addr_q, int_enable_offset)) begin
      next_int_enable = wval & int_bits_mask;
    end
    if (write_to(wr_hit, addr_q, sw_reset_offset) &&
        wval[sw_reset_bit]) begin
      sw_reset = 1'b1;
    end

    // Hardware moves the state only out of suspend.
    if ((state_of(ctrl) == state_suspended) && resume_sync) begin // [RULE11]
      next_ctrl[fs_hi:fs_lo] = state_bus_resume; // [RULE12]
      events[bit_resume_detect] = 1'b1;
    end

    if (sw_reset) begin
      // Wake-connected and routing survive a software reset.
      next_ctrl = sw_reset_keep(ctrl); // [RULE3]
      next_ctrl[fs_hi:fs_lo] = state_suspended; // [RULE13]
    end

    events[bit_frame_start] = frame_pulse; // [RULE10]

    if (write_to(wr_hit, addr_q, int_status_offset)) begin
      next_int_status = int_status & ~(wval & int_bits_mask);
    end
    // A new event beats a simultaneous clear.
    next_int_status = next_int_status | events;

    pending       = next_int_status & next_int_enable;
    next_bus_irq  = (|pending) && !next_ctrl[bit_irq_route]; // [RULE4]
    next_mgmt_irq = (|pending) && next_ctrl[bit_irq_route];  // [RULE5]
    next_host_wake = next_ctrl[bit_wake_enable] &&
                     next_int_status[bit_resume_detect]; // [RULE14]
    next_port_reset_drive =
      (next_ctrl[fs_hi:fs_lo] == state_bus_reset); // [RULE13]
    // Frames stop in the same cycle in which the state leaves running.
    next_frame_enable = (frame_started || frame_pulse) &&
                        (state_of(next_ctrl) == state_running); // [RULE9]
    next_prev_state   = ctrl[fs_hi:fs_lo];

    next_hrdata = hrdata;
    // Read data is prepared at the address phase and stands until the next.
    if (take_transfer(hsel, hready, htrans) && !hwrite) begin
      next_hrdata = read_mux(haddr, next_ctrl, next_int_status,
                             next_int_enable); // [RULE1] [RULE8]
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl             <= ctrl_reset_value; // [RULE3] [RULE13]
      int_status       <= 32'h0000_0000;
      int_enable       <= 32'h0000_0000;
      hrdata           <= 32'h0000_0000;
      bus_irq          <= 1'b0;
      mgmt_irq         <= 1'b0;
      host_wake        <= 1'b0;
      port_reset_drive <= 1'b1;
      frame_enable     <= 1'b0;
      prev_state       <= state_bus_reset;
    end else begin
      ctrl             <= next_ctrl;
      int_status       <= next_int_status;
      int_enable       <= next_int_enable;
      hrdata           <= next_hrdata;
      bus_irq          <= next_bus_irq;
      mgmt_irq         <= next_mgmt_irq;
      host_wake        <= next_host_wake;
      port_reset_drive <= next_port_reset_drive;
      frame_enable     <= next_frame_enable;
      prev_state       <= next_prev_state;
    end
  end

  // The slave never stretches a transfer and never reports an error.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

endmodule

`default_nettype wire

// [src/host_ctrl_pkg.sv]
package host_ctrl_pkg;

  localparam logic [11:0] ctrl_offset        = 12'h004;
  localparam logic [11:0] int_status_offset  = 12'h00C;
  localparam logic [11:0] int_enable_offset  = 12'h010;
  localparam logic [11:0] sw_reset_offset    = 12'h008;

  localparam int unsigned bit_wake_enable    = 10;
  localparam int unsigned bit_wake_connected = 9;
  localparam int unsigned bit_irq_route      = 8;
  localparam int unsigned fs_hi              = 7;
  localparam int unsigned fs_lo              = 6;

  localparam int unsigned bit_frame_start    = 2;
  localparam int unsigned bit_resume_detect  = 3;
  localparam int unsigned sw_reset_bit       = 0;

  localparam logic [31:0] ctrl_reset_value   = 32'h0000_0000;
  localparam logic [31:0] ctrl_rw_mask       = 32'h0000_07FF;
  localparam logic [31:0] int_bits_mask      = 32'h0000_000C;

  localparam int unsigned clk_period_ns      = 10;
  localparam int unsigned frame_delay_ns     = 1000000;
  localparam int unsigned frame_delay_cycles =
    frame_delay_ns / clk_period_ns;

  typedef enum logic [1:0] {
    state_bus_reset  = 2'b00,
    state_bus_resume = 2'b01,
    state_running    = 2'b10,
    state_suspended  = 2'b11
  } functional_state_t;

  localparam logic [1:0] htrans_nonseq = 2'b10;

endpackage

// [src/frame_start_timer.sv]
`timescale 1ns/1ps
`default_nettype none

// Counts the delay from entry into the running state to the first frame.
module frame_start_timer #(
  parameter int unsigned delay_cycles = 100000
) (
  // Clock and reset.
  input  wire logic hclk,
  input  wire logic hresetn,
  // Control.
  input  wire logic arm,
  input  wire logic running,
  // Result.
  output logic      started,
  output logic      start_pulse
);

  initial begin
    if (delay_cycles < 1) begin
      $error("delay_cycles must be at least one");
    end
  end

  logic [31:0] count;
  logic [31:0] next_count;
  logic        next_started;
  logic        next_start_pulse;

  always_comb begin
    next_count       = count;
    next_started     = started;
    next_start_pulse = 1'b0;
    if (!running) begin
      next_count   = 32'h0000_0000;
      next_started = 1'b0;
    end else if (arm) begin
      next_count   = 32'h0000_0000;
      next_started = 1'b0;
    end else if (!started) begin
      if (count >= delay_cycles - 1) begin
        next_started     = 1'b1;
        next_start_pulse = 1'b1;
      end else begin
        next_count = count + 32'h0000_0001;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      count       <= 32'h0000_0000;
      started     <= 1'b0;
      start_pulse <= 1'b0;
    end else begin
      count       <= next_count;
      started     <= next_started;
      start_pulse <= next_start_pulse;
    end
  end

endmodule

`default_nettype wire

// [test/host_ctrl_chk.sv]
`timescale 1ns/1ps
`default_nettype none
module host_ctrl_chk
  import host_ctrl_pkg::*;
#(
  parameter int unsigned frame_cycles = 20
) (
  // Clock and reset.
  input wire logic        hclk,
  input wire logic        hresetn,
  // Bus.
  input wire logic        hsel,
  input wire logic [11:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic [31:0] hwdata,
  // System side.
  input wire logic        port_resume_detect,
  input wire logic        bus_irq,
  input wire logic        mgmt_irq,
  input wire logic        host_wake,
  input wire logic        port_reset_drive,
  input wire logic        frame_enable
);
  localparam int lo = frame_cycles - 2;
  localparam int hi = frame_cycles + 6;
  logic        ap_wr;
  logic [11:0] ap_a;
  logic        wm;
  logic        rt;
  logic        run_wr;
  assign run_wr = ap_wr && ap_a == ctrl_offset && hwdata[7:6] == 2'b10;
  // Mirrors wake enable and routing from the writes seen on the bus.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ap_wr <= 1'b0;
      ap_a <= 12'h000;
      wm <= 1'b0;
      rt <= 1'b0;
    end else begin
      if (hready) begin
        ap_wr <= hsel && hwrite && htrans == htrans_nonseq;
        ap_a <= haddr;
      end
      if (ap_wr && ap_a == ctrl_offset) begin
        wm <= hwdata[10];
        rt <= hwdata[8];
      end else if (ap_wr && ap_a == sw_reset_offset && hwdata[0]) begin
        wm <= 1'b0;
      end
    end
  end
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  AST_ONE_IRQ: assert property (!(bus_irq && mgmt_irq))
    else $error("both interrupt outputs high");
  AST_ROUTE_BUS: assert property ((!rt)[*3] |-> !mgmt_irq)
    else $error("management irq while routed to bus");
  AST_ROUTE_MGMT: assert property (rt[*3] |-> !bus_irq)
    else $error("bus irq while routed to management");
  AST_WAKE_GATE: assert property ((!wm)[*3] |-> !host_wake)
    else $error("host wake without wake enable");
  AST_HW_RESET: assert property (
    $rose(hresetn) |-> port_reset_drive)
    else $error("no port reset after hardware reset");
  AST_FRAME_QUIET: assert property (run_wr && port_reset_drive |=>
    (!frame_enable)[*8]) else $error("frames started too early");
  AST_FRAME_START: assert property (run_wr && port_reset_drive |->
    ##[lo:hi] $rose(frame_enable)) else $error("frames did not start");
  AST_NO_RST_FRAME: assert property (
    !(port_reset_drive && frame_enable))
    else $error("frames during bus reset state");
  AST_RUN_KEEP: assert property (
    $rose(port_resume_detect) && frame_enable |=> frame_enable[*4])
    else $error("resume altered running state");
  cover property ($rose(frame_enable));
  cover property ($rose(host_wake));
  cover property (rt && mgmt_irq);
endmodule
bind host_ctrl_state host_ctrl_chk #(.frame_cycles(frame_cycles)) chk_u (
  .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hready, .hwdata,
  .port_resume_detect, .bus_irq, .mgmt_irq, .host_wake, .port_reset_drive,
  .frame_enable);
`default_nettype wire

// [test/port_model.sv]
`timescale 1ns/1ps
`default_nettype none
module port_model (
  // Clock.
  input  wire logic hclk,
  // Resume line towards the controller.
  output var logic  resume
);
  initial resume = 1'b0;
  // Holds resume signaling for n cycles; a slow device uses a long n.
  task automatic signal_resume(input int n);
    @(posedge hclk);
    resume <= 1'b1;
    repeat (n) @(posedge hclk);
    resume <= 1'b0;
  endtask
endmodule
`default_nettype wire

// [test/tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin miscompares++; \
  $display("Error t=%0t got %h exp %h", $time, (a), (b)); end end
`define WT(c) begin k = 0; while (!(c) && k < 60) begin \
  @(posedge hclk); k++; end end
module tb_top
  import host_ctrl_pkg::*;
;
  localparam int fc = 20;
  logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
  logic        bus_irq, mgmt_irq, host_wake, port_reset_drive, frame_enable;
  logic        resume;
  logic [11:0] haddr;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] hwdata, hrdata, q;
  int          miscompares = 0, checked = 0, cycles = 0, k;
  assign hready = hreadyout;
  host_ctrl_state #(.frame_cycles(fc)) dut_u (.hclk, .hresetn, .hsel, .haddr,
    .htrans, .hwrite, .hsize, .hready, .hwdata, .hrdata, .hreadyout, .hresp,
    .port_resume_detect(resume), .bus_irq, .mgmt_irq, .host_wake,
    .port_reset_drive, .frame_enable);
  port_model port_u (.hclk, .resume);
  task automatic xfer(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= htrans_nonseq;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask
  task automatic rd(input logic [11:0] a);
    xfer(1'b0, a, 32'h0000_0000);
  endtask
  task automatic s_reset;
    rd(ctrl_offset);
    `CHK(q, ctrl_reset_value)
    `CHK(hreadyout, 1'b1)
    `CHK(hresp, 1'b0)
    `CHK(port_reset_drive, 1'b1)
    rd(12'h0FC);
    `CHK(q, 32'h0000_0000)
  endtask
  task automatic s_states;
    for (int s = 0; s < 4; s++) begin
      wr(ctrl_offset, {22'h0, 2'b10, s[1:0], 6'h00});
      rd(ctrl_offset);
      `CHK(q, {22'h0, 2'b10, s[1:0], 6'h00})
      `WT(port_reset_drive === (s == 0))
      `CHK(port_reset_drive, s == 0)
    end
  endtask
  task automatic s_frames;
    wr(ctrl_offset, 32'h0000_0000);
    wr(ctrl_offset, 32'h0000_0080);
    `CHK(frame_enable, 1'b0)
    `WT(frame_enable)
    `CHK((k >= fc - 3) && (k <= fc + 6), 1'b1)
    rd(int_status_offset);
    `CHK(q[bit_frame_start], 1'b1)
    wr(int_enable_offset, 32'h0000_0004);
    `WT(bus_irq)
    `CHK({bus_irq, mgmt_irq}, 2'b10)
    wr(ctrl_offset, 32'h0000_0180);
    `WT(mgmt_irq)
    `CHK({bus_irq, mgmt_irq}, 2'b01)
    wr(int_enable_offset, 32'h0000_0000);
    `WT(!mgmt_irq)
    `CHK({bus_irq, mgmt_irq}, 2'b00)
    wr(ctrl_offset, 32'h0000_0100);
    @(posedge hclk);
    `CHK({port_reset_drive, frame_enable}, 2'b10)
    wr(ctrl_offset, 32'h0000_0180);
    `WT(frame_enable)
    `CHK(frame_enable, 1'b1)
  endtask
  task automatic s_resume;
    port_u.signal_resume(4);
    rd(ctrl_offset);
    `CHK(q[7:6], 2'b10)
    `CHK(frame_enable, 1'b1)
    wr(ctrl_offset, 32'h0000_07C0);
    port_u.signal_resume(6);
    `WT(host_wake)
    `CHK(host_wake, 1'b1)
    rd(ctrl_offset);
    `CHK(q[7:6], 2'b01)
    rd(int_status_offset);
    `CHK(q[bit_resume_detect], 1'b1)
    wr(int_status_offset, 32'h0000_000C);
    `WT(!host_wake)
    `CHK(host_wake, 1'b0)
  endtask
  task automatic s_swreset;
    wr(sw_reset_offset, 32'h0000_0001);
    rd(ctrl_offset);
    `CHK(q, 32'h0000_03C0)
    `CHK(q[bit_wake_connected], 1'b1)
    @(posedge hclk);
    hresetn <= 1'b0;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    rd(ctrl_offset);
    `CHK(q, 32'h0000_0000)
    `CHK(port_reset_drive, 1'b1)
    wr(ctrl_offset, 32'h0000_0000);
    rd(ctrl_offset);
    `CHK(q[bit_irq_route], 1'b0)
  endtask
  task automatic conclude;
    $display("checks %0d errors %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end
  always @(posedge hclk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      miscompares++;
      conclude;
    end
  end
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 12'h000;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h0000_0000;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    s_reset;
    s_states;
    s_frames;
    s_resume;
    s_swreset;
    conclude;
  end
endmodule
`default_nettype wire
